// >>> hdl/miw_top.v
`timescale 1ns/10ps
`include "miw_regs.vh"
// How it works
// (RL1) NMI or enabled channel event takes any low-power mode back to Active through the main and PLL waits.
// (RL2) Wake: clear main disable, await main stable, clear PLL disable, await PLL stable.
// (RL3) Clock flags read 1 when stable; PLL flag also reads 1 while PLL disabled.
// (RL4) Mode requests wait until the target mode's clock flag is set.
// (RL5) No slow crystal: slow clock from main, main stops only in Idle/Halt.
// (RL6) No slow crystal: leaving Idle/Halt lands Active with main feeding slow.
// (RL7) Sixteen channels; trigger raises interrupt, and wake request only when enabled.
// (RL8) Wake request restarts clocks only; code resumes through the routed interrupt.
// (RL9) Four routed interrupt request outputs; each channel drives exactly one.
// (RL10) Channels 0 to 15 fixed sources; channels 6 and 8 reserved.
// (RL11) Edge select 0 rising, 1 falling; resets to all rising.
// (RL12) Each trigger latches pending; wake-enabled pending channel gives active signal.
// (RL13) Pending register reads one bit per channel.
// (RL14) Edge capture works without any clock, even in Halt.
// (RL15) Wake enable bit per channel; clears on reset.
// (RL16) Interrupt enable bit per channel gates its routed request.
// (RL17) Low routing register: 2-bit field for channels 0-7, resets zero.
// (RL18) High routing register: 2-bit field for channels 8-15, resets zero.
// (RL19) Pending clears on reset; writing 1 sets a bit, 0 leaves it.
// (RL20) Pending-clear register: write 1 clears, 0 no effect, write-only.
// (RL21) An NMI wake event stays latched until interrupt acknowledge or reset.
// (RL22) Wake is OR of pending and enable; request k ORs routed enabled pendings.
// (RL23) Captured pending flags are synchronised before reads and irq_req; wake_req also takes the raw captures.
module miw_top #(
	parameter CH = 16,
	parameter AW = 24,
	parameter DW = 16,
	parameter NIRQ = 4
) (
	input wire clk,
	input wire rst,
	input wire [AW-1:0] bus_addr,
	input wire [DW-1:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output wire [DW-1:0] bus_rdata,
	input wire [CH-1:0] wake_in,
	input wire nmi_in,
	input wire main_osc_stable,
	input wire pll_stable,
	input wire slow_osc_stable,
	input wire slow_xtal_present,
	input wire mode_req,
	input wire [3:0] mode_req_code,
	input wire irq_ack,
	output wire [NIRQ-1:0] irq_req,
	output wire wake_req,
	output wire main_osc_en,
	output wire pll_en,
	output wire slow_clk_from_main,
	output wire [3:0] power_mode
);
	localparam ST_ACTIVE = 6'b000001;
	localparam ST_PSAVE = 6'b000010;
	localparam ST_IDLE = 6'b000100;
	localparam ST_HALT = 6'b001000;
	localparam ST_WMAIN = 6'b010000;
	localparam ST_WPLL = 6'b100000;

	reg [DW-1:0] edge_sel_reg;
	reg [DW-1:0] wake_en_reg;
	reg [DW-1:0] route_lo_reg;
	reg [DW-1:0] route_hi_reg;
	reg [DW-1:0] irq_en_reg;
	reg [CH-1:0] pend_reg;
	reg [CH-1:0] pend_next;
	reg [CH-1:0] clr_reg;
	reg [DW-1:0] rdata_reg;
	reg [DW-1:0] rdata_next;
	reg dmc_reg;
	reg dhc_reg;
	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg req_pend_reg;
	reg req_take;
	reg [3:0] req_code_reg;
	reg wake_seen_reg;
	reg nmi_prev_reg;
	reg main_en_reg;
	reg pll_en_reg;
	reg [3:0] mode_reg;
	reg [3:0] mode_next;

	wire [CH-1:0] src_masked;
	wire [CH-1:0] cap_flag;
	wire [CH+4:0] sync_in;
	wire [CH+4:0] sync_out;
	wire [CH-1:0] flag_sync;
	wire [CH-1:0] cap_set;
	wire nmi_sync;
	wire main_sync;
	wire pll_sync;
	wire slow_sync;
	wire xtal_sync;
	wire main_flag;
	wire pll_flag;
	wire slow_flag;
	wire wake_evt;
	wire [2*CH-1:0] route_all;
	wire wr_edge;
	wire wr_wen;
	wire wr_rlo;
	wire wr_rhi;
	wire wr_pend;
	wire wr_pcl;
	wire wr_ien;
	wire wr_ctrl;

	// Reserved channels have no source and never trigger
	assign src_masked = wake_in & ~`MIW_RSVD_MASK; // see (RL10)

	miw_edge_latch #(
		.CH(CH)
	) u_latch (
		.wake_in(src_masked),
		.edge_fall(edge_sel_reg[CH-1:0]),
		.clr(clr_reg),
		.flag(cap_flag)
	);

	// Bring captured flags and clock status pins into the clock domain
	assign sync_in = {slow_xtal_present, slow_osc_stable, pll_stable, main_osc_stable,
		nmi_in, cap_flag};

	miw_sync #(
		.W(CH + 5)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d_in(sync_in),
		.q_out(sync_out)
	);

	assign flag_sync = sync_out[CH-1:0]; // see (RL23)
	assign nmi_sync = sync_out[CH];
	assign main_sync = sync_out[CH+1];
	assign pll_sync = sync_out[CH+2];
	assign slow_sync = sync_out[CH+3];
	assign xtal_sync = sync_out[CH+4];

	// New capture is the rising edge of the synchronised flag
	assign cap_set = flag_sync & ~clr_reg;

	// Clock status flags as seen by the sequencer and software
	assign main_flag = main_sync; // see (RL3)
	assign pll_flag = pll_sync | ~pll_en_reg; // see (RL3)
	assign slow_flag = xtal_sync ? slow_sync : main_sync; // see (RL5)

	// Write decode
	assign wr_edge = bus_wr && (bus_addr == `MIW_EDGE_SEL_ADDR);
	assign wr_wen = bus_wr && (bus_addr == `MIW_WAKE_EN_ADDR);
	assign wr_rlo = bus_wr && (bus_addr == `MIW_ROUTE_LO_ADDR);
	assign wr_rhi = bus_wr && (bus_addr == `MIW_ROUTE_HI_ADDR);
	assign wr_pend = bus_wr && (bus_addr == `MIW_PEND_ADDR);
	assign wr_pcl = bus_wr && (bus_addr == `MIW_PEND_CLR_ADDR);
	assign wr_ien = bus_wr && (bus_addr == `MIW_IRQ_EN_ADDR);
	assign wr_ctrl = bus_wr && (bus_addr == `MIW_PWR_CTRL_ADDR);

	// Configuration registers
	always @(posedge clk)
	begin
		if (rst)
		begin
			edge_sel_reg <= `MIW_EDGE_SEL_RST; // see (RL11)
			wake_en_reg <= `MIW_WAKE_EN_RST; // see (RL15)
			route_lo_reg <= `MIW_ROUTE_RST; // see (RL17)
			route_hi_reg <= `MIW_ROUTE_RST; // see (RL18)
			irq_en_reg <= `MIW_IRQ_EN_RST;
		end
		else
		begin
			if (wr_edge)
				edge_sel_reg <= bus_wdata;
			if (wr_wen)
				wake_en_reg <= bus_wdata; // see (RL15)
			if (wr_rlo)
				route_lo_reg <= bus_wdata; // see (RL17)
			if (wr_rhi)
				route_hi_reg <= bus_wdata; // see (RL18)
			if (wr_ien)
				irq_en_reg <= bus_wdata; // see (RL16)
		end
	end

	// Pending: clear-by-one, set-by-one, capture wins over a clear
	always @*
	begin
		pend_next = pend_reg;
		if (wr_pcl)
			pend_next = pend_next & ~bus_wdata[CH-1:0]; // see (RL20)
		if (wr_pend)
			pend_next = pend_next | bus_wdata[CH-1:0]; // see (RL19)
		pend_next = (pend_next | cap_set) & ~`MIW_RSVD_MASK; // see (RL12)
	end

	// Async flag is held cleared until its synchronised copy has fallen
	always @(posedge clk)
	begin
		if (rst)
		begin
			pend_reg <= `MIW_PEND_RST; // see (RL19)
			clr_reg <= `MIW_CLR_RST;
		end
		else
		begin
			pend_reg <= pend_next;
			clr_reg <= flag_sync;
		end
	end

	// Routed interrupt requests, one route field per channel
	assign route_all = {route_hi_reg, route_lo_reg};
	genvar k;
	generate
		for (k = 0; k < NIRQ; k = k + 1)
		begin : g_irq
			wire [CH-1:0] hit;
			genvar n;
			for (n = 0; n < CH; n = n + 1)
			begin : g_ch
				assign hit[n] = (route_all[`MIW_ROUTE_W*n +: `MIW_ROUTE_W] == k); // see (RL9)
			end
			assign irq_req[k] = |(pend_reg & irq_en_reg[CH-1:0] & hit); // see (RL22)
		end
	endgenerate

	// Wake request needs no clock: raw captures count as well as pending bits
	assign wake_req = (|((cap_flag | pend_reg) & wake_en_reg[CH-1:0])) | wake_seen_reg; // see (RL7)
	// Wake restarts clocks only; the routed interrupt resumes code
	assign wake_evt = (|(pend_reg & wake_en_reg[CH-1:0])) | wake_seen_reg; // see (RL8)

	// NMI wake latch, held until interrupt acknowledge; set wins
	always @(posedge clk)
	begin
		if (rst)
		begin
			wake_seen_reg <= 1'b0;
			nmi_prev_reg <= 1'b0;
		end
		else
		begin
			nmi_prev_reg <= nmi_sync;
			if (nmi_sync && !nmi_prev_reg)
				wake_seen_reg <= 1'b1; // see (RL21)
			else if (irq_ack)
				wake_seen_reg <= 1'b0; // see (RL21)
		end
	end

	// Power mode sequencer
	always @*
	begin
		state_next = state_reg;
		req_take = 1'b0;
		case (state_reg)
			ST_ACTIVE:
			begin
				if (req_pend_reg)
				begin
					if (req_code_reg == `MIW_MODE_PSAVE || req_code_reg == `MIW_MODE_IDLE ||
						req_code_reg == `MIW_MODE_HALT)
					begin
						if (slow_flag) // see (RL4)
						begin
							req_take = 1'b1;
							if (req_code_reg == `MIW_MODE_PSAVE)
								state_next = ST_PSAVE;
							else if (req_code_reg == `MIW_MODE_IDLE)
								state_next = ST_IDLE;
							else
								state_next = ST_HALT;
						end
					end
					else
						req_take = 1'b1;
				end
			end
			ST_PSAVE:
			begin
				if (wake_evt)
					state_next = ST_WMAIN; // see (RL1)
				else if (req_pend_reg)
				begin
					if (req_code_reg != `MIW_MODE_ACTIVE)
						req_take = 1'b1;
					else if (main_flag && pll_flag) // see (RL4)
					begin
						req_take = 1'b1;
						state_next = ST_ACTIVE;
					end
				end
			end
			ST_IDLE, ST_HALT:
			begin
				if (wake_evt)
					state_next = ST_WMAIN; // see (RL1)
				else if (req_pend_reg)
					req_take = 1'b1;
			end
			ST_WMAIN:
			begin
				if (main_flag)
					state_next = ST_WPLL; // see (RL2)
			end
			ST_WPLL:
			begin
				if (pll_flag)
					state_next = ST_ACTIVE; // see (RL2)
			end
			default:
				state_next = ST_ACTIVE;
		endcase
	end

	// Mode reported per state; wait states report no settled mode
	always @*
	begin
		case (state_next)
			ST_ACTIVE: mode_next = `MIW_MODE_ACTIVE;
			ST_PSAVE: mode_next = `MIW_MODE_PSAVE;
			ST_IDLE: mode_next = `MIW_MODE_IDLE;
			ST_HALT: mode_next = `MIW_MODE_HALT;
			default: mode_next = `MIW_MODE_NONE;
		endcase
	end

	// Sequencer state, request holding, disable bits and clock enables
	always @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= ST_ACTIVE;
			req_pend_reg <= 1'b0;
			req_code_reg <= `MIW_MODE_NONE;
			dmc_reg <= 1'b0;
			dhc_reg <= 1'b0;
			main_en_reg <= 1'b1;
			pll_en_reg <= 1'b1;
			mode_reg <= `MIW_MODE_ACTIVE;
		end
		else
		begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			if (mode_req)
			begin
				req_pend_reg <= 1'b1;
				req_code_reg <= mode_req_code;
			end
			else if (req_take)
				req_pend_reg <= 1'b0;
			// Hardware clearing during wake beats a software write
			if (state_next == ST_WMAIN)
				dmc_reg <= 1'b0; // see (RL2)
			else if (wr_ctrl)
				dmc_reg <= bus_wdata[`MIW_CTRL_DMC_BIT];
			if (state_next == ST_WPLL)
				dhc_reg <= 1'b0; // see (RL2)
			else if (wr_ctrl)
				dhc_reg <= bus_wdata[`MIW_CTRL_DHC_BIT];
			// Main oscillator stops in Idle/Halt, in Power Save only with a slow crystal
			main_en_reg <= !(state_next == ST_IDLE || state_next == ST_HALT) &&
				!(state_next == ST_PSAVE && dmc_reg && xtal_sync); // see (RL5)
			pll_en_reg <= !(state_next == ST_IDLE || state_next == ST_HALT ||
				state_next == ST_WMAIN) && !(state_next == ST_PSAVE && dhc_reg);
		end
	end

	assign main_osc_en = main_en_reg;
	assign pll_en = pll_en_reg;
	assign slow_clk_from_main = ~xtal_sync; // see (RL6)
	assign power_mode = mode_reg;

	// Read mux; pending-clear and unmapped addresses read zero
	always @*
	begin
		rdata_next = {DW{1'b0}};
		case (bus_addr)
			`MIW_EDGE_SEL_ADDR: rdata_next = edge_sel_reg;
			`MIW_WAKE_EN_ADDR: rdata_next = wake_en_reg;
			`MIW_ROUTE_LO_ADDR: rdata_next = route_lo_reg;
			`MIW_ROUTE_HI_ADDR: rdata_next = route_hi_reg;
			`MIW_PEND_ADDR: rdata_next[CH-1:0] = pend_reg; // see (RL13)
			`MIW_IRQ_EN_ADDR: rdata_next = irq_en_reg;
			`MIW_PWR_STAT_ADDR:
			begin
				rdata_next[`MIW_STAT_PLL_BIT] = pll_flag;
				rdata_next[`MIW_STAT_MAIN_BIT] = main_flag;
				rdata_next[`MIW_STAT_SLOW_BIT] = slow_flag;
			end
			`MIW_PWR_CTRL_ADDR:
			begin
				rdata_next[`MIW_CTRL_DMC_BIT] = dmc_reg;
				rdata_next[`MIW_CTRL_DHC_BIT] = dhc_reg;
				rdata_next[`MIW_CTRL_MODE_MSB:`MIW_CTRL_MODE_LSB] = mode_reg;
			end
			default: rdata_next = {DW{1'b0}};
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk)
	begin
		if (rst)
			rdata_reg <= {DW{1'b0}};
		else if (bus_rd)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= {DW{1'b0}};
	end

	assign bus_rdata = rdata_reg;
endmodule

// >>> hdl/miw_regs.vh
`ifndef MIW_REGS_VH
`define MIW_REGS_VH

// Register byte addresses
`define MIW_EDGE_SEL_ADDR 24'hfffc80
`define MIW_WAKE_EN_ADDR 24'hfffc82
`define MIW_ROUTE_LO_ADDR 24'hfffc84
`define MIW_ROUTE_HI_ADDR 24'hfffc86
`define MIW_PEND_ADDR 24'hfffc88
`define MIW_PEND_CLR_ADDR 24'hfffc8a
`define MIW_IRQ_EN_ADDR 24'hfffc8c
`define MIW_PWR_STAT_ADDR 24'hfffc8e
`define MIW_PWR_CTRL_ADDR 24'hfffc90

// Reset values
`define MIW_EDGE_SEL_RST 16'h0000
`define MIW_WAKE_EN_RST 16'h0000
`define MIW_ROUTE_RST 16'h0000
`define MIW_PEND_RST 16'h0000
`define MIW_IRQ_EN_RST 16'h0000
`define MIW_CLR_RST 16'hffff

// Channels without a source
`define MIW_RSVD_MASK 16'h0140

// Routing field width per channel
`define MIW_ROUTE_W 2

// Power status fields
`define MIW_STAT_PLL_BIT 0
`define MIW_STAT_MAIN_BIT 1
`define MIW_STAT_SLOW_BIT 2

// Power control fields
`define MIW_CTRL_DMC_BIT 0
`define MIW_CTRL_DHC_BIT 1
`define MIW_CTRL_MODE_LSB 4
`define MIW_CTRL_MODE_MSB 7

// Power mode codes, one-hot except none (zero)
`define MIW_MODE_NONE 4'h0
`define MIW_MODE_ACTIVE 4'h1
`define MIW_MODE_PSAVE 4'h2
`define MIW_MODE_IDLE 4'h4
`define MIW_MODE_HALT 4'h8

`endif

// >>> hdl/miw_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser; output follows once stages two and three agree
module miw_sync #(
	parameter W = 8
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	reg [W-1:0] q_reg;
	wire [W-1:0] agree;

	assign agree = ~(s2_reg ^ s3_reg);
	assign q_out = q_reg;

	// Shift chain and agreement filter
	always @(posedge clk)
	begin
		if (rst)
		begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
			s3_reg <= {W{1'b0}};
			q_reg <= {W{1'b0}};
		end
		else
		begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg <= (q_reg & ~agree) | (s3_reg & agree);
		end
	end
endmodule

// >>> hdl/miw_edge_latch.v
`timescale 1ns/10ps
// Clockless edge capture: each channel input clocks its own set flop
module miw_edge_latch #(
	parameter CH = 16
) (
	input wire [CH-1:0] wake_in,
	input wire [CH-1:0] edge_fall,
	input wire [CH-1:0] clr,
	output wire [CH-1:0] flag
);
	genvar i;
	generate
		for (i = 0; i < CH; i = i + 1)
		begin : g_ch
			reg flag_reg;
			wire trig;

			// Falling select inverts the input so a rising trig is always the event
			assign trig = wake_in[i] ^ edge_fall[i]; // see (RL11)
			assign flag[i] = flag_reg;

			// Capture runs with no system clock, cleared from the clock domain
			always @(posedge trig or posedge clr[i])
			begin
				if (clr[i])
					flag_reg <= 1'b0;
				else
					flag_reg <= 1'b1; // see (RL14)
			end
		end
	endgenerate
endmodule

// >>> verif/miw_chk.sv
`timescale 1ns/10ps
`include "miw_regs.vh"
// Port checker for the wake unit
module miw_chk #(
	parameter CH = 16,
	parameter AW = 24,
	parameter DW = 16,
	parameter NIRQ = 4
) (
	input wire clk,
	input wire rst,
	input wire [AW-1:0] bus_addr,
	input wire [DW-1:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [DW-1:0] bus_rdata,
	input wire nmi_in,
	input wire main_osc_stable,
	input wire pll_stable,
	input wire slow_xtal_present,
	input wire [NIRQ-1:0] irq_req,
	input wire wake_req,
	input wire main_osc_en,
	input wire pll_en,
	input wire slow_clk_from_main,
	input wire [3:0] power_mode
);
	// Single clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 0)
		else $error("read data outside answer cycle");
	a_clr_reads_zero: assert property (bus_rd && bus_addr == `MIW_PEND_CLR_ADDR
		|=> bus_rdata == 0) else $error("clear register read not zero");
	a_ien_off: assert property (bus_wr && bus_addr == `MIW_IRQ_EN_ADDR && bus_wdata == 0
		|=> irq_req == 0) else $error("request with interrupts disabled");
	a_clear_all: assert property (bus_wr && bus_addr == `MIW_PEND_CLR_ADDR
		&& bus_wdata == 16'hffff |=> irq_req == 0) else $error("request after full clear");
	a_wait_main: assert property (power_mode == `MIW_MODE_NONE |-> main_osc_en)
		else $error("main oscillator off during wake wait");
	a_pll_order: assert property ($rose(pll_en) |-> main_osc_en && $past(main_osc_stable))
		else $error("PLL enabled before main oscillator stable");
	a_active_gate: assert property (power_mode == `MIW_MODE_ACTIVE
		&& $past(power_mode) == `MIW_MODE_NONE |-> $past(pll_stable) && $past(main_osc_stable))
		else $error("active entered before clocks stable");
	a_nmi_wake: assert property ($rose(nmi_in) && power_mode == `MIW_MODE_PSAVE
		|-> ##[1:8] power_mode != `MIW_MODE_PSAVE) else $error("NMI did not leave power save");
	a_slow_src: assert property ($stable(slow_xtal_present) [*6]
		|-> slow_clk_from_main == !slow_xtal_present) else $error("slow clock source wrong");
	// Main scenarios reached
	cover property (power_mode == `MIW_MODE_NONE);
	cover property ($rose(wake_req));
	cover property (irq_req != 0);
endmodule

bind miw_top miw_chk #(.CH(CH), .AW(AW), .DW(DW), .NIRQ(NIRQ)) u_chk (
	.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .nmi_in(nmi_in), .pll_stable(pll_stable),
	.main_osc_stable(main_osc_stable), .slow_xtal_present(slow_xtal_present),
	.irq_req(irq_req), .wake_req(wake_req), .main_osc_en(main_osc_en), .pll_en(pll_en),
	.slow_clk_from_main(slow_clk_from_main), .power_mode(power_mode)
);

// >>> verif/miw_osc_model.sv
`timescale 1ns/10ps
// Oscillators and PLL as the wake sequencer sees them
module miw_osc_model (
	input wire clk,
	input wire [7:0] dly,
	input wire main_osc_en,
	input wire pll_en,
	output reg main_osc_stable,
	output reg pll_stable,
	output reg slow_osc_stable
);
	reg [7:0] main_cnt = 8'h00;
	reg [7:0] pll_cnt = 8'h00;
	reg [7:0] slow_cnt = 8'h00;
	initial
	begin
		main_osc_stable = 1'b0;
		pll_stable = 1'b0;
		slow_osc_stable = 1'b0;
	end
	// Stable only after dly enabled cycles; PLL runs off the main oscillator
	always @(posedge clk)
	begin
		main_cnt <= !main_osc_en ? 8'h00 : (main_cnt < dly) ? main_cnt + 8'h01 : main_cnt;
		pll_cnt <= !(pll_en && main_osc_stable) ? 8'h00 : (pll_cnt < dly) ? pll_cnt + 8'h01 : pll_cnt;
		slow_cnt <= (slow_cnt < 8'h10) ? slow_cnt + 8'h01 : slow_cnt;
		main_osc_stable <= main_osc_en && main_cnt >= dly;
		pll_stable <= pll_en && main_osc_stable && pll_cnt >= dly;
		slow_osc_stable <= slow_cnt >= 8'h10;
	end
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
`include "miw_regs.vh"
// Randomised bench for the wake unit
module tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [23:0] bus_addr = 24'h000000;
	reg [15:0] bus_wdata = 16'h0000;
	reg bus_wr = 1'b0;
	reg bus_rd = 1'b0;
	reg [15:0] wake_in = 16'h0000;
	reg nmi_in = 1'b0;
	reg slow_xtal_present = 1'b1;
	reg mode_req = 1'b0;
	reg [3:0] mode_req_code = 4'h0;
	reg irq_ack = 1'b0;
	reg [7:0] dly = 8'h03;
	wire [15:0] bus_rdata;
	wire [3:0] irq_req;
	wire [3:0] power_mode;
	wire wake_req, main_osc_en, pll_en, slow_clk_from_main;
	wire main_osc_stable, pll_stable, slow_osc_stable;
	integer seed = 32'hca7a2f6e;
	integer err_total = 0;
	integer checked = 0;
	integer c, k, r32;
	reg [15:0] cfg [0:6];
	reg [15:0] p;
	reg [3:0] m;
	always #20 clk = ~clk;
	miw_top u_dut (
		.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .wake_in(wake_in), .nmi_in(nmi_in),
		.main_osc_stable(main_osc_stable), .pll_stable(pll_stable),
		.slow_osc_stable(slow_osc_stable), .slow_xtal_present(slow_xtal_present),
		.mode_req(mode_req), .mode_req_code(mode_req_code), .irq_ack(irq_ack),
		.irq_req(irq_req), .wake_req(wake_req), .main_osc_en(main_osc_en), .pll_en(pll_en),
		.slow_clk_from_main(slow_clk_from_main), .power_mode(power_mode)
	);
	miw_osc_model u_osc (
		.clk(clk), .dly(dly), .main_osc_en(main_osc_en), .pll_en(pll_en),
		.main_osc_stable(main_osc_stable), .pll_stable(pll_stable),
		.slow_osc_stable(slow_osc_stable)
	);
	// Routed requests that enabled pending channels should raise
	function [3:0] irq_exp(input [15:0] pd, input [15:0] en, input [15:0] lo, input [15:0] hi);
		integer i;
		reg [1:0] r;
		begin
			irq_exp = 4'h0;
			for (i = 0; i < 16; i = i + 1)
			begin
				r = (i < 8) ? lo[2*i +: 2] : hi[2*i-16 +: 2];
				if (pd[i] && en[i])
					irq_exp[r] = 1'b1;
			end
		end
	endfunction
	task chk(input [15:0] seen, input [15:0] exp, input [63:0] name);
		begin
			checked = checked + 1;
			if (seen !== exp)
			begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0s exp %h seen %h", name, exp, seen);
			end
		end
	endtask
	task wr(input [23:0] a, input [15:0] d);
		begin
			@(posedge clk);
			bus_wr <= 1'b1;
			bus_addr <= a;
			bus_wdata <= d;
			@(posedge clk);
			bus_wr <= 1'b0;
		end
	endtask
	task rd(input [23:0] a, input [15:0] exp);
		begin
			@(posedge clk);
			bus_rd <= 1'b1;
			bus_addr <= a;
			@(posedge clk);
			bus_rd <= 1'b0;
			#1;
			chk(bus_rdata, exp, "rdata");
		end
	endtask
	// Waits a bounded time for a power mode
	task wait_mode(input [3:0] mm);
		integer n;
		begin
			n = 0;
			while (power_mode !== mm && n < 300)
			begin
				@(posedge clk);
				n = n + 1;
			end
			#1;
			chk({12'h000, power_mode}, {12'h000, mm}, "mode");
		end
	endtask
	task test_done;
		begin
			$display("checked %0d err_total %0d", checked, err_total);
			if (err_total == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial
	begin
		#(40 * 20000);
		err_total = err_total + 1;
		test_done;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		// Reset values, plus an unmapped address
		for (c = 0; c < 7; c = c + 1)
			rd(24'hfffc80 + {c[22:0], 1'b0}, 16'h0000);
		rd(24'hfffcf0, 16'h0000);
		for (k = 0; k < 2; k = k + 1)
		begin
			// Random configuration, written and read back
			for (c = 0; c < 7; c = c + 1)
			begin
				r32 = $random(seed);
				cfg[c] = r32[15:0];
				if (c < 4 || c == 6)
				begin
					wr(24'hfffc80 + {c[22:0], 1'b0}, cfg[c]);
					rd(24'hfffc80 + {c[22:0], 1'b0}, cfg[c]);
				end
			end
			wake_in <= cfg[0];
			repeat (8) @(posedge clk);
			wr(`MIW_PEND_CLR_ADDR, 16'hffff);
			// Write-one-set and write-one-clear; reserved channels stay low
			p = cfg[4] & ~`MIW_RSVD_MASK;
			wr(`MIW_PEND_ADDR, cfg[4]);
			rd(`MIW_PEND_ADDR, p);
			chk({12'h000, irq_req}, {12'h000, irq_exp(p, cfg[6], cfg[2], cfg[3])}, "irq");
			chk({15'h0000, wake_req}, {15'h0000, |(p & cfg[1])}, "wake");
			wr(`MIW_IRQ_EN_ADDR, 16'h0000);
			#1;
			chk({12'h000, irq_req}, 16'h0000, "irq");
			wr(`MIW_IRQ_EN_ADDR, cfg[6]);
			wr(`MIW_PEND_CLR_ADDR, cfg[5]);
			rd(`MIW_PEND_ADDR, p & ~cfg[5]);
			wr(`MIW_PEND_CLR_ADDR, 16'hffff);
			// Each channel but reserved 6 and 8 captures its edge and keeps it through the opposite one
			for (c = 0; c < 16; c = c + 1)
			begin
				p = 16'h0001 << c & ~`MIW_RSVD_MASK;
				wake_in[c] <= ~wake_in[c];
				repeat (8) @(posedge clk);
				chk({15'h0000, wake_req}, {15'h0000, |(p & cfg[1])}, "wake");
				chk({12'h000, irq_req}, {12'h000, irq_exp(p, cfg[6], cfg[2], cfg[3])}, "irq");
				wake_in[c] <= ~wake_in[c];
				repeat (8) @(posedge clk);
				rd(`MIW_PEND_ADDR, p);
				wr(`MIW_PEND_CLR_ADDR, 16'hffff);
			end
		end
		// Low-power entry, then wake by NMI or by an enabled channel
		for (k = 0; k < 3; k = k + 1)
		begin
			if (k == 2)
				slow_xtal_present <= 1'b0;
			dly <= (k == 1) ? 8'h14 : 8'h03;
			m = (k == 0) ? `MIW_MODE_PSAVE : (k == 1) ? `MIW_MODE_HALT : `MIW_MODE_IDLE;
			repeat (8) @(posedge clk);
			wr(`MIW_WAKE_EN_ADDR, 16'h0001);
			wr(`MIW_PWR_CTRL_ADDR, 16'h0003);
			@(posedge clk);
			mode_req <= 1'b1;
			mode_req_code <= m;
			@(posedge clk);
			mode_req <= 1'b0;
			wait_mode(m);
			repeat (20) @(posedge clk);
			chk({14'h0000, main_osc_en, pll_en}, 16'h0000, "osc");
			if (k == 0)
			begin
				rd(`MIW_PWR_STAT_ADDR, 16'h0005);
				// Return to Active is held off while the main oscillator is off
				@(posedge clk);
				mode_req <= 1'b1;
				mode_req_code <= `MIW_MODE_ACTIVE;
				@(posedge clk);
				mode_req <= 1'b0;
				repeat (20) @(posedge clk);
				chk({12'h000, power_mode}, {12'h000, `MIW_MODE_PSAVE}, "mode");
			end
			if (k == 1)
				wake_in[0] <= ~wake_in[0];
			else
				nmi_in <= 1'b1;
			wait_mode(`MIW_MODE_ACTIVE);
			chk({15'h0000, pll_stable}, 16'h0001, "pll");
			rd(`MIW_PWR_CTRL_ADDR, 16'h0010);
			chk({15'h0000, slow_clk_from_main}, {15'h0000, k == 2}, "slow");
			nmi_in <= 1'b0;
			rd(`MIW_PEND_ADDR, {15'h0000, k == 1});
			chk({15'h0000, wake_req}, 16'h0001, "wake");
			@(posedge clk);
			irq_ack <= 1'b1;
			@(posedge clk);
			irq_ack <= 1'b0;
			wr(`MIW_PEND_CLR_ADDR, 16'hffff);
			repeat (2) @(posedge clk);
			chk({15'h0000, wake_req}, 16'h0000, "wake");
		end
		test_done;
	end
endmodule
